// ===== rtl/data_rom_pkg.sv
// package for the data rom nibble reader: sfr offsets, rom geometry, vectors
// assumes a 4-bit core with a 5-bit sfr address space in the common block
package data_rom_pkg;
  // special function register offsets
  localparam logic [4:0] ADDR_NIBBLE0 = 5'h18;
  localparam logic [4:0] ADDR_NIBBLE1 = 5'h19;
  localparam logic [4:0] ADDR_NIBBLE2 = 5'h1a;
  localparam logic [4:0] ADDR_NIBBLE3 = 5'h1b;
  localparam logic [4:0] DATA_LOW     = 5'h1c;
  localparam logic [4:0] DATA_HIGH    = 5'h1d;
  localparam logic [4:0] ADDR_NIBBLE4 = 5'h1e;
  // geometry
  localparam int NIBBLE_W  = 4;
  localparam int DADDR_W   = 20;
  localparam int PADDR_W   = 13;
  localparam int PWORD_W   = 12;
  // data rom limits per program rom option
  localparam logic [19:0] DATA_ROM_LAST_4K = 20'h3_dfff;
  localparam logic [19:0] DATA_ROM_LAST_8K = 20'h3_bfff;
  localparam logic [19:0] DATA_ROM_SYS_SPAN = 20'h0_0040; // trailing system area
  // program rom limits and fills
  localparam logic [12:0] PROGRAM_ROM_LAST_4K = 13'h0fff;
  localparam logic [12:0] PROGRAM_ROM_LAST_8K = 13'h1fff;
  localparam logic [12:0] PROGRAM_ROM_RSV_4K  = 13'h0f00;
  localparam logic [12:0] PROGRAM_ROM_RSV_8K  = 13'h1f00;
  localparam logic [11:0] FILL_ONES    = 12'hfff;
  localparam logic [11:0] FILL_ZEROS   = 12'h000;
  // core entry vectors
  localparam logic [12:0] VEC_RESET  = 13'h0000;
  localparam logic [12:0] VEC_WAKEUP = 13'h0004;
  localparam logic [12:0] VEC_INTR   = 13'h0008;
  localparam logic [12:0] USER_START = 13'h000a;
  // data ready time, in core clocks, and its cycle count
  localparam int TDRR_CLOCKS = 2;
  localparam int TDRR_CYC    = TDRR_CLOCKS;
  // sfr access from the core
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [4:0] addr;
    logic [3:0] wdata;
  } sfr_req_t;
  // data rom fetch port
  typedef struct packed {
    logic        req;
    logic [19:0] addr;
  } data_rom_req_t;
endpackage

// ===== rtl/data_rom_nibble_reader.sv
// data rom nibble reader: address nibble sfrs, data nibble sfrs, rom fetch,
// program rom option map and fetch fill.
// assumes rom macros outside answer a fetch with data in the same cycle as the request.
// Contract
// - data rom words are bytes, read by the core as two nibbles
// - five address nibbles form the address, 18h lowest, 1eh highest
// - address nibbles at 18h,19h,1ah,1bh,1eh, readable and writable
// - data valid within two clocks of an address write; software waits
// - reading 1ch returns data bits 3 to 0
// - reading 1dh returns data bits 7 to 4
// - writing 1dh restarts watchdog when watchdog option is on
// - data rom capacity follows program rom size option
// - program rom holds 12-bit words, 0fffh or 1fffh top
// - reset entry 000h, wakeup 004h, interrupt 008h, user code 00ah
// - unused program words read fff with reserve fill, else 000
`timescale 1ns/1ns
module data_rom_nibble_reader #(
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  // build options
  input  wire logic                     program_rom_8k_option,
  input  wire logic                     watchdog_option,
  input  wire logic                     reserve_fill_option,
  // core sfr port
  input  wire data_rom_pkg::sfr_req_t       sfr_req,
  output logic [3:0]                    sfr_rdata,
  output logic                          sfr_hit,
  // data rom macro
  output data_rom_pkg::data_rom_req_t           data_rom_req,
  input  wire logic [DATA_W-1:0]        data_rom_rdata,
  // watchdog
  output logic                          watchdog_restart,
  // program rom fetch
  input  wire logic [12:0]              program_rom_fetch_addr,
  input  wire logic [11:0]              program_rom_raw_word,
  input  wire logic                     program_rom_word_used,
  output logic [11:0]                   program_rom_word,
  output logic [19:0]                   data_rom_last_addr,
  output logic [12:0]                   program_rom_last_addr,
  output logic [12:0]                   program_rom_reserved_start,
  output logic [12:0]                   vec_reset,
  output logic [12:0]                   vec_wakeup,
  output logic [12:0]                   vec_intr,
  output logic [12:0]                   vec_user,
  output logic                          data_ready
);

  // address nibble storage, indexed 0..4
  logic [3:0] nib      [5];
  logic [3:0] next_nib [5];
  logic [DATA_W-1:0] data_q, next_data_q;
  logic       fetch_q, next_fetch_q;
  logic [1:0] wait_cnt, next_wait_cnt;
  logic [11:0] word_q, next_word_q;
  logic       wdt_q, next_wdt_q;

  // map an sfr offset to an address nibble index, 7 when not one
  function automatic logic [2:0] nib_index(input logic [4:0] a);
    case (a)
      data_rom_pkg::ADDR_NIBBLE0: nib_index = 3'd0;
      data_rom_pkg::ADDR_NIBBLE1: nib_index = 3'd1;
      data_rom_pkg::ADDR_NIBBLE2: nib_index = 3'd2;
      data_rom_pkg::ADDR_NIBBLE3: nib_index = 3'd3;
      data_rom_pkg::ADDR_NIBBLE4: nib_index = 3'd4;
      default:                nib_index = 3'd7;
    endcase
  endfunction

  logic [2:0]  widx, ridx;
  logic [19:0] full_addr;
  assign widx = nib_index(sfr_req.addr);
  assign ridx = widx;
  // nibble 0 lowest, nibble 4 highest
  assign full_addr = {nib[4], nib[3], nib[2], nib[1], nib[0]};

  // address nibble writes; no reset value, as the sfrs power up undefined
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      next_nib[i] = nib[i];
    end
    if (sfr_req.wr && widx != 3'd7) begin
      next_nib[widx] = sfr_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 5; i++) begin
      nib[i] <= next_nib[i];
    end
  end

  // fetch: any address write restarts the two-clock ready window
  always_comb begin
    next_fetch_q  = 1'b0;
    next_wait_cnt = wait_cnt;
    next_data_q   = data_q;
    if (sfr_req.wr && widx != 3'd7) begin
      next_wait_cnt = 2'(data_rom_pkg::TDRR_CYC);
    end else if (wait_cnt != 2'd0) begin
      next_wait_cnt = wait_cnt - 2'd1;
    end
    // one cycle after a write the new address reaches the macro
    if (wait_cnt == 2'(data_rom_pkg::TDRR_CYC)) begin
      next_fetch_q = 1'b1;
    end
    if (fetch_q) begin
      next_data_q = data_rom_rdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fetch_q  <= 1'b0;
      wait_cnt <= 2'd0;
      data_q   <= '0;
    end else begin
      fetch_q  <= next_fetch_q;
      wait_cnt <= next_wait_cnt;
      data_q   <= next_data_q;
    end
  end

  // address beyond the option's capacity is not checked; system area too
  assign data_rom_req.req  = fetch_q;
  assign data_rom_req.addr = full_addr;
  assign data_ready    = (wait_cnt == 2'd0);

  // sfr read mux; data nibble writes store nothing
  always_comb begin
    sfr_hit   = 1'b1;
    sfr_rdata = 4'h0;
    if (ridx != 3'd7) begin
      sfr_rdata = nib[ridx];
    end else if (sfr_req.addr == data_rom_pkg::DATA_LOW) begin
      sfr_rdata = data_q[3:0];
    end else if (sfr_req.addr == data_rom_pkg::DATA_HIGH) begin
      sfr_rdata = data_q[7:4];
    end else begin
      sfr_hit = 1'b0;
    end
  end

  // watchdog restart pulse, registered
  always_comb begin
    next_wdt_q = watchdog_option && sfr_req.wr &&
                 sfr_req.addr == data_rom_pkg::DATA_HIGH;
  end

  // program word: fill value for unused words
  always_comb begin
    if (program_rom_word_used && program_rom_fetch_addr <= program_rom_last_addr) begin
      next_word_q = program_rom_raw_word;
    end else if (reserve_fill_option) begin
      next_word_q = data_rom_pkg::FILL_ONES;
    end else begin
      next_word_q = data_rom_pkg::FILL_ZEROS;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wdt_q  <= 1'b0;
      word_q <= data_rom_pkg::FILL_ZEROS;
    end else begin
      wdt_q  <= next_wdt_q;
      word_q <= next_word_q;
    end
  end

  assign watchdog_restart = wdt_q;
  assign program_rom_word        = word_q;

  // option-dependent map; reserved program area is advisory only
  assign data_rom_last_addr      = program_rom_8k_option ? data_rom_pkg::DATA_ROM_LAST_8K
                                              : data_rom_pkg::DATA_ROM_LAST_4K;
  assign program_rom_last_addr      = program_rom_8k_option ? data_rom_pkg::PROGRAM_ROM_LAST_8K
                                              : data_rom_pkg::PROGRAM_ROM_LAST_4K;
  assign program_rom_reserved_start = program_rom_8k_option ? data_rom_pkg::PROGRAM_ROM_RSV_8K
                                              : data_rom_pkg::PROGRAM_ROM_RSV_4K;
  // fixed core entry points
  assign vec_reset  = data_rom_pkg::VEC_RESET;
  assign vec_wakeup = data_rom_pkg::VEC_WAKEUP;
  assign vec_intr   = data_rom_pkg::VEC_INTR;
  assign vec_user   = data_rom_pkg::USER_START;

endmodule // data_rom_nibble_reader

// ===== tb/data_rom_model.sv
// data rom model: byte derived from the fetch address
// assumes the reader's fetch port on the same clock
`timescale 1ns/1ns
module data_rom_model (
  // clock and fetch port
  input  wire logic                sys_clk,
  input  wire data_rom_pkg::data_rom_req_t data_rom_req,
  output logic [7:0]               data_rom_rdata
);
  logic       req_d;
  logic [7:0] junk = 8'h5a;
  // bus toggles outside the window so a sample more than one cycle late cannot pass
  always_ff @(posedge sys_clk) {req_d, junk} <= {data_rom_req.req, ~junk};
  assign data_rom_rdata = (data_rom_req.req | req_d) ? data_rom_req.addr[7:0] ^ data_rom_req.addr[19:12] : junk;
endmodule // data_rom_model

// ===== tb/data_rom_reader_props.sv
// checker for the data rom nibble reader ports
// assumes one clock and a synchronous reset
`timescale 1ns/1ns
module data_rom_reader_props (
  // clock, reset, options
  input wire logic                sys_clk,
  input wire logic                sys_rst,
  input wire logic                program_rom_8k_option,
  input wire logic                watchdog_option,
  // sfr and rom sides
  input wire data_rom_pkg::sfr_req_t  sfr_req,
  input wire logic [3:0]          sfr_rdata,
  input wire data_rom_pkg::data_rom_req_t data_rom_req,
  input wire logic [7:0]          data_rom_rdata,
  input wire logic                watchdog_restart,
  input wire logic [19:0]         data_rom_last_addr,
  input wire logic                data_ready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic       aw, hw, rl, rh;
  logic [7:0] seen;
  // write and read strobes as the design samples them
  assign aw = sfr_req.wr && sfr_req.addr inside {[5'h18:5'h1b], 5'h1e};
  assign hw = sfr_req.wr && sfr_req.addr == 5'h1d;
  assign rl = data_ready && sfr_req.rd && sfr_req.addr == 5'h1c;
  assign rh = data_ready && sfr_req.rd && sfr_req.addr == 5'h1d;
  // last byte handed over; zero like the cleared data byte
  always_ff @(posedge sys_clk) seen <= sys_rst ? 8'h00 : data_rom_req.req ? data_rom_rdata : seen;
  property p_busy; aw |=> !data_ready; endproperty
  property p_ready; aw ##1 !aw [*2] |=> data_ready; endproperty
  property p_low; rl |-> sfr_rdata == seen[3:0]; endproperty
  property p_high; rh |-> sfr_rdata == seen[7:4]; endproperty
  property p_top; sfr_req.rd && sfr_req.addr == 5'h1e |-> sfr_rdata == data_rom_req.addr[19:16]; endproperty
  property p_wdog; hw |=> watchdog_restart == $past(watchdog_option); endproperty
  property p_cause; watchdog_restart |-> $past(hw); endproperty
  property p_cap; data_rom_last_addr == (program_rom_8k_option ? 20'h3_bfff : 20'h3_dfff); endproperty
  a_busy: assert property (p_busy) else $error("ready during fetch");
  a_ready: assert property (p_ready) else $error("data late");
  a_low: assert property (p_low) else $error("low nibble wrong");
  a_high: assert property (p_high) else $error("high nibble wrong");
  a_top: assert property (p_top) else $error("top nibble wrong");
  a_wdog: assert property (p_wdog) else $error("restart wrong");
  a_cause: assert property (p_cause) else $error("stray restart");
  a_cap: assert property (p_cap) else $error("capacity wrong");
  c_fetch: cover property (data_rom_req.req);
  c_wdog: cover property (watchdog_restart);
  c_8k: cover property (program_rom_8k_option && rh);
endmodule // data_rom_reader_props
bind data_rom_nibble_reader data_rom_reader_props chk (.*);

// ===== tb/data_rom_nibble_reader_tb.sv
// bench: random and corner fetches, readback, watchdog writes, option maps
// assumes the rom model and the bound checker
`timescale 1ns/1ns
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin mismatches++; $display("Error %0t got %h exp %h", $time, g, x); end end
module data_rom_nibble_reader_tb;
  logic                sys_clk, sys_rst, program_rom_8k_option, watchdog_option, reserve_fill_option;
  logic                program_rom_word_used, sfr_hit, watchdog_restart, data_ready;
  data_rom_pkg::sfr_req_t  sfr_req;
  data_rom_pkg::data_rom_req_t data_rom_req;
  logic [3:0]          sfr_rdata;
  logic [7:0]          data_rom_rdata;
  logic [11:0]         program_rom_raw_word, program_rom_word, pw;
  logic [12:0]         program_rom_fetch_addr, program_rom_last_addr, vec_reset, vec_wakeup, vec_intr, vec_user;
  logic [12:0]         program_rom_reserved_start;
  logic [19:0]         a, data_rom_last_addr;
  logic [4:0]          offs [5];
  int                  checks, mismatches;
  data_rom_nibble_reader uut (.*);
  data_rom_model rom (.*);
  // one request per edge; the next call replaces it, so wr stays one pulse
  task automatic acc(logic r, logic w, logic [4:0] ad, logic [3:0] d);
    @(posedge sys_clk) sfr_req <= '{r, w, ad, d};
    @(negedge sys_clk);
  endtask
  // back-to-back address writes, two idle cycles, then reads and a data-high write
  task automatic fetch(logic [19:0] x);
    logic [7:0] e;
    e = x[7:0] ^ x[19:12];
    for (int k = 0; k < 5; k++) acc(1'b0, 1'b1, offs[k], x[4*k+:4]);
    repeat (2) acc(1'b0, 1'b0, 5'h00, 4'h0);
    acc(1'b1, 1'b0, data_rom_pkg::DATA_LOW, 4'h0);
    `CHK({data_ready, sfr_rdata}, {1'b1, e[3:0]})
    acc(1'b0, 1'b1, data_rom_pkg::DATA_HIGH, ~e[7:4]);
    acc(1'b1, 1'b0, data_rom_pkg::DATA_HIGH, 4'h0);
    `CHK({watchdog_restart, sfr_rdata}, {watchdog_option, e[7:4]})
    for (int k = 0; k < 5; k++) begin
      acc(1'b1, 1'b0, offs[k], 4'h0);
      `CHK(sfr_rdata, x[4*k+:4])
    end
  endtask
  // closing report for the main sequence and the watchdog
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // a hang of the sequence ends the run as a failure
  initial begin
    #200_000;
    mismatches++;
    print_verdict();
  end
  initial begin
    {sys_rst, program_rom_8k_option, watchdog_option, reserve_fill_option, program_rom_word_used} = 5'h10;
    {sfr_req, program_rom_fetch_addr, program_rom_raw_word} = '0;
    offs = '{data_rom_pkg::ADDR_NIBBLE0, data_rom_pkg::ADDR_NIBBLE1, data_rom_pkg::ADDR_NIBBLE2,
             data_rom_pkg::ADDR_NIBBLE3, data_rom_pkg::ADDR_NIBBLE4};
    a = 20'($urandom(32'hc732));
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    acc(1'b1, 1'b0, 5'h05, 4'h0);
    `CHK({sfr_hit, sfr_rdata}, 5'h00)
    `CHK({vec_reset, vec_wakeup, vec_intr, vec_user}, {13'h0000, 13'h0004, 13'h0008, 13'h000a})
    // corners first, then random addresses and options
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      {program_rom_8k_option, watchdog_option, reserve_fill_option, program_rom_word_used} <= 4'($urandom);
      {program_rom_fetch_addr, program_rom_raw_word} <= 25'($urandom);
      // last 4k-option user byte below the system area, then the full 20-bit reach
      a = (i == 0) ? 20'h3_dfbf : (i == 1) ? 20'hf_ffff : 20'($urandom);
      fetch(a);
      pw = reserve_fill_option ? 12'hfff : 12'h000;
      if (program_rom_word_used && program_rom_fetch_addr <= (program_rom_8k_option ? 13'h1fff : 13'h0fff)) pw = program_rom_raw_word;
      `CHK(program_rom_word, pw)
      `CHK(program_rom_last_addr, program_rom_8k_option ? 13'h1fff : 13'h0fff)
      `CHK(program_rom_reserved_start, program_rom_8k_option ? 13'h1f00 : 13'h0f00)
    end
    print_verdict();
  end
endmodule // data_rom_nibble_reader_tb
